// ==== split_strobe_host_bus_port.sv ====
// Purpose: Host bus port in split-strobe mode, bridging host cycles to core arbitration.
// Assumes: Host pins are timed by host_xfer_clk_i; straps are static around reset.
// Notes:   One access in flight; words cross by toggle handshake on stable registers.
`timescale 1ns/1ns
`include "port_consts.svh"
module split_strobe_host_bus_port (
    input  wire logic        clock_i,
    input  wire logic        sys_rst_i,
    input  wire logic        host_xfer_clk_i,
    input  wire logic        panel_ctrl_select_n_i,
    input  wire logic        read_strobe_n_i,
    input  wire logic        low_write_strobe_n_i,
    input  wire logic        upper_byte_strobe_n_i,
    input  wire logic        port_addr_msb_i,
    input  wire logic [15:1] port_addr_in_i,
    input  wire logic        port_addr_lsb_i,
    input  wire logic [15:0] port_data_i,
    input  wire logic        bus_status_n_i,
    input  wire logic        rd_wr_dir_i,
    input  wire logic        strap_mode_bit0_i,
    input  wire logic        strap_mode_bit1_i,
    input  wire logic        strap_mode_bit2_i,
    input  wire logic        strap_byte_order_i,
    input  wire logic        acc_grant_i,
    input  wire logic [15:0] acc_rdata_i,
    output logic [15:0]      port_data_o,
    output logic             port_data_oe_o,
    output logic             panel_ctrl_ready_n_o,
    output logic             acc_req_o,
    output logic             acc_we_o,
    output logic             acc_mem_sel_o,
    output logic             acc_reg_sel_o,
    output logic [16:0]      acc_addr_o,
    output logic [1:0]       acc_be_o,
    output logic [15:0]      acc_wdata_o,
    output logic             split_mode_o,
    output logic             big_endian_o
);

    ////////////////////////////////////////////////////////////////////////////
    // Crossings
    logic                    link_rst, split_l, ack_l, req_l;
    logic                    req_tog_reg, ack_tog_reg;
    logic [`STRAP_BITS-1:0]  strap_pins, strap_s;
    // Direction pin is never looked at in this mode
    assign strap_pins = {bus_status_n_i, strap_byte_order_i, strap_mode_bit2_i,
                         strap_mode_bit1_i, strap_mode_bit0_i};
    bit_sync u_rst_sync (
        .clk_i   (host_xfer_clk_i),
        .async_i (sys_rst_i),
        .sync_o  (link_rst)
    );
    bit_sync u_split_sync (
        .clk_i   (host_xfer_clk_i),
        .async_i (split_mode_o),
        .sync_o  (split_l)
    );
    bit_sync u_ack_sync (
        .clk_i   (host_xfer_clk_i),
        .async_i (ack_tog_reg),
        .sync_o  (ack_l)
    );
    bit_sync u_req_sync (
        .clk_i   (clock_i),
        .async_i (req_tog_reg),
        .sync_o  (req_l)
    );
    genvar gi;
    generate
        for (gi = 0; gi < `STRAP_BITS; gi = gi + 1) begin : g_strap
            bit_sync u_strap_sync (
                .clk_i   (clock_i),
                .async_i (strap_pins[gi]),
                .sync_o  (strap_s[gi])
            );
        end
    endgenerate
    ////////////////////////////////////////////////////////////////////////////
    // Link side, on the host bus clock
    port_pkg::link_state_t lstate_reg, lstate_next;
    logic                  ready_n_next, oe_next, req_tog_next;
    logic                  ack_seen_reg, ack_seen_next;
    logic [16:0]           cap_addr_reg, cap_addr_next;
    logic                  cap_we_reg, cap_we_next, cap_word_reg, cap_word_next;
    logic [15:0]           dout_next, cap_wdata_reg, cap_wdata_next, rdata_reg;
    logic                  host_sel, host_rd, host_wr;
    assign host_sel = ~panel_ctrl_select_n_i;
    assign host_rd  = ~read_strobe_n_i;
    assign host_wr  = ~low_write_strobe_n_i;
    always_comb begin
        lstate_next    = lstate_reg;
        ready_n_next   = panel_ctrl_ready_n_o;
        oe_next        = port_data_oe_o;
        dout_next      = port_data_o;
        req_tog_next   = req_tog_reg;
        ack_seen_next  = ack_seen_reg;
        cap_addr_next  = cap_addr_reg;
        cap_we_next    = cap_we_reg;
        cap_word_next  = cap_word_reg;
        cap_wdata_next = cap_wdata_reg;
        case (lstate_reg)
            port_pkg::LINK_IDLE: begin
                ready_n_next = `READY_IDLE;
                oe_next      = 1'b0;
                if (split_l && host_sel && (host_rd ^ host_wr)) begin
                    cap_addr_next  = {port_addr_msb_i, port_addr_in_i, port_addr_lsb_i};
                    cap_wdata_next = port_data_i;
                    cap_we_next    = host_wr;
                    cap_word_next  = ~upper_byte_strobe_n_i;
                    req_tog_next   = ~req_tog_reg;
                    lstate_next    = port_pkg::LINK_WAIT;
                end
            end
            port_pkg::LINK_WAIT: begin
                ready_n_next = `READY_IDLE;
                if (ack_l != ack_seen_reg) begin
                    ack_seen_next = ack_l;
                    dout_next     = rdata_reg;
                    oe_next       = ~cap_we_reg;
                    ready_n_next  = `READY_DONE;
                    lstate_next   = port_pkg::LINK_DONE;
                end
            end
            port_pkg::LINK_DONE: begin
                // Hold until the host ends the cycle, so one cycle is one access
                if (!host_sel || !(host_rd || host_wr)) begin
                    ready_n_next = `READY_IDLE;
                    oe_next      = 1'b0;
                    lstate_next  = port_pkg::LINK_IDLE;
                end
            end
            default: begin
                lstate_next = port_pkg::LINK_IDLE;
            end
        endcase
    end
    always_ff @(posedge host_xfer_clk_i) begin
        if (link_rst) begin
            lstate_reg           <= port_pkg::LINK_IDLE;
            panel_ctrl_ready_n_o <= `READY_IDLE;
            port_data_oe_o       <= 1'b0;
            port_data_o          <= `DATA_RST;
            req_tog_reg          <= 1'b0;
            ack_seen_reg         <= 1'b0;
            cap_addr_reg         <= `ADDR_RST;
            cap_we_reg           <= 1'b0;
            cap_word_reg         <= 1'b0;
            cap_wdata_reg        <= `DATA_RST;
        end else begin
            lstate_reg           <= lstate_next;
            panel_ctrl_ready_n_o <= ready_n_next;
            port_data_oe_o       <= oe_next;
            port_data_o          <= dout_next;
            req_tog_reg          <= req_tog_next;
            ack_seen_reg         <= ack_seen_next;
            cap_addr_reg         <= cap_addr_next;
            cap_we_reg           <= cap_we_next;
            cap_word_reg         <= cap_word_next;
            cap_wdata_reg        <= cap_wdata_next;
        end
    end
    a_ready_low_pend: assert property (
        @(posedge host_xfer_clk_i) disable iff (link_rst)
        (lstate_reg == port_pkg::LINK_WAIT) |-> !panel_ctrl_ready_n_o)
        else $error("ready released while access pending");
    a_ready_on_ack: assert property (
        @(posedge host_xfer_clk_i) disable iff (link_rst)
        (lstate_reg == port_pkg::LINK_WAIT && ack_l != ack_seen_reg)
        |=> panel_ctrl_ready_n_o && (port_data_oe_o == !cap_we_reg))
        else $error("ready or data drive wrong after answer");
    a_ready_idle_low: assert property (
        @(posedge host_xfer_clk_i) disable iff (link_rst)
        (lstate_reg == port_pkg::LINK_IDLE) |-> !panel_ctrl_ready_n_o && !port_data_oe_o)
        else $error("ready high or bus driven while idle");

    ////////////////////////////////////////////////////////////////////////////
    // Straps, on the core clock
    logic                   rst_d_reg, strap_take, split_next, endian_next;
    // Capture on the first cycle after release, from synchronised pins
    assign strap_take  = rst_d_reg && !sys_rst_i;
    always_comb begin
        split_next  = split_mode_o;
        endian_next = big_endian_o;
        if (strap_take) begin
            split_next  = ((strap_s & `STRAP_SPLIT) == `STRAP_SPLIT);
            endian_next = strap_s[`STRAP_ORDER];
        end
    end
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            rst_d_reg    <= 1'b1;
            split_mode_o <= 1'b0;
            big_endian_o <= 1'b0;
        end else begin
            rst_d_reg    <= 1'b0;
            split_mode_o <= split_next;
            big_endian_o <= endian_next;
        end
    end
    a_strap_mode: assert property (
        @(posedge clock_i) disable iff (sys_rst_i)
        (rst_d_reg && !sys_rst_i)
        |=> (split_mode_o == (($past(strap_s) & `STRAP_SPLIT) == `STRAP_SPLIT))
        ##1 $stable(split_mode_o))
        else $error("bus mode not taken from straps at release");
    a_strap_order: assert property (
        @(posedge clock_i) disable iff (sys_rst_i)
        (rst_d_reg && !sys_rst_i) |=> (big_endian_o == $past(strap_s[`STRAP_ORDER])))
        else $error("byte order not taken from strap at release");
    ////////////////////////////////////////////////////////////////////////////
    // Core side: decode and arbitration request
    port_pkg::core_state_t  cstate_reg, cstate_next;
    logic                   req_seen_reg, req_seen_next, ack_tog_next, acc_req_next;
    logic                   acc_we_next, mem_sel_next, reg_sel_next, hit_mem, hit_reg;
    logic [16:0]            acc_addr_next;
    logic [1:0]             acc_be_next, be_host;
    logic [15:0]            acc_wdata_next, rdata_next;
    assign hit_mem = (cap_addr_reg < `MEM_TOP);
    assign hit_reg = (cap_addr_reg >= `REG_BASE);
    assign be_host = cap_word_reg ? `BE_WORD : (cap_addr_reg[0] ? `BE_HIGH : `BE_LOW);
    // Link registers are stable while the toggle is in flight
    always_comb begin
        cstate_next    = cstate_reg;
        req_seen_next  = req_seen_reg;
        ack_tog_next   = ack_tog_reg;
        acc_req_next   = acc_req_o;
        acc_we_next    = acc_we_o;
        mem_sel_next   = acc_mem_sel_o;
        reg_sel_next   = acc_reg_sel_o;
        acc_addr_next  = acc_addr_o;
        acc_be_next    = acc_be_o;
        acc_wdata_next = acc_wdata_o;
        rdata_next     = rdata_reg;
        case (cstate_reg)
            port_pkg::CORE_IDLE: begin
                if (split_mode_o && req_l != req_seen_reg) begin
                    req_seen_next  = req_l;
                    acc_addr_next  = cap_addr_reg;
                    acc_we_next    = cap_we_reg;
                    mem_sel_next   = hit_mem;
                    reg_sel_next   = hit_reg;
                    // Big endian swaps byte lanes and their enables
                    acc_be_next    = big_endian_o ? {be_host[0], be_host[1]} : be_host;
                    acc_wdata_next = big_endian_o ? {cap_wdata_reg[7:0], cap_wdata_reg[15:8]}
                                                  : cap_wdata_reg;
                    if (hit_mem || hit_reg) begin
                        acc_req_next = 1'b1;
                        cstate_next  = port_pkg::CORE_REQ;
                    end else begin
                        // Hole in the map: reads zero, writes dropped
                        rdata_next   = `DATA_RST;
                        ack_tog_next = ~ack_tog_reg;
                    end
                end
            end
            port_pkg::CORE_REQ: begin
                if (acc_grant_i) begin
                    acc_req_next = 1'b0;
                    rdata_next   = big_endian_o ? {acc_rdata_i[7:0], acc_rdata_i[15:8]}
                                                : acc_rdata_i;
                    ack_tog_next = ~ack_tog_reg;
                    cstate_next  = port_pkg::CORE_IDLE;
                end
            end
            default: begin
                cstate_next = port_pkg::CORE_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            cstate_reg    <= port_pkg::CORE_IDLE;
            req_seen_reg  <= 1'b0;
            ack_tog_reg   <= 1'b0;
            acc_req_o     <= 1'b0;
            acc_we_o      <= 1'b0;
            acc_mem_sel_o <= 1'b0;
            acc_reg_sel_o <= 1'b0;
            acc_addr_o    <= `ADDR_RST;
            acc_be_o      <= `BE_RST;
            acc_wdata_o   <= `DATA_RST;
            rdata_reg     <= `DATA_RST;
        end else begin
            cstate_reg    <= cstate_next;
            req_seen_reg  <= req_seen_next;
            ack_tog_reg   <= ack_tog_next;
            acc_req_o     <= acc_req_next;
            acc_we_o      <= acc_we_next;
            acc_mem_sel_o <= mem_sel_next;
            acc_reg_sel_o <= reg_sel_next;
            acc_addr_o    <= acc_addr_next;
            acc_be_o      <= acc_be_next;
            acc_wdata_o   <= acc_wdata_next;
            rdata_reg     <= rdata_next;
        end
    end

    a_req_holds: assert property (
        @(posedge clock_i) disable iff (sys_rst_i)
        (acc_req_o && !acc_grant_i) |=> acc_req_o && $stable(acc_addr_o) && $stable(acc_be_o))
        else $error("request dropped or changed before grant");
    a_grant_answers: assert property (
        @(posedge clock_i) disable iff (sys_rst_i)
        (acc_req_o && acc_grant_i) |=> !acc_req_o && (ack_tog_reg != $past(ack_tog_reg)))
        else $error("grant did not end request with an answer");
    a_decode_window: assert property (
        @(posedge clock_i) disable iff (sys_rst_i)
        $rose(acc_req_o) |-> (acc_mem_sel_o == (acc_addr_o < `MEM_TOP))
                             && (acc_reg_sel_o == (acc_addr_o >= `REG_BASE)))
        else $error("memory or register window decoded wrong");
    a_byte_lane: assert property (
        @(posedge clock_i) disable iff (sys_rst_i)
        ($rose(acc_req_o) && !big_endian_o)
        |-> (acc_be_o == `BE_WORD) || (acc_be_o == (acc_addr_o[0] ? `BE_HIGH : `BE_LOW)))
        else $error("byte lane does not follow address lsb");
    a_split_only: assert property (
        @(posedge clock_i) disable iff (sys_rst_i)
        !split_mode_o |-> !acc_req_o)
        else $error("access issued outside split-strobe mode");

endmodule

// ==== port_consts.svh ====
// Purpose: Constants for the split-strobe host bus port.
// Assumes: Included by bare name; definitions only.
// Notes:   Addresses are byte addresses within one 128K byte block.
`ifndef PORT_CONSTS_SVH
`define PORT_CONSTS_SVH

// Address map
`define ADDR_BITS      17
`define MEM_TOP        17'h14000
`define REG_BASE       17'h1ffe0

// Strap layout: {bus_status_n, byte_order, mode2, mode1, mode0}
`define STRAP_BITS     5
// Split mode needs mode bits and status high; byte order is free
`define STRAP_SPLIT    5'h17
`define STRAP_ORDER    3
`define STRAP_RST      5'h00

// Reset values, byte enables and ready levels
`define DATA_RST       16'h0000
`define ADDR_RST       17'h00000
`define BE_RST         2'h0
`define BE_WORD        2'h3
`define BE_LOW         2'h1
`define BE_HIGH        2'h2
`define READY_IDLE     1'h0
`define READY_DONE     1'h1

`endif

// ==== port_pkg.sv ====
// Purpose: Types shared by the split-strobe host bus port.
// Assumes: Compiled before the modules that use it.
// Notes:   State encodings are left to the tools.
package port_pkg;

    typedef enum logic [1:0] {
        LINK_IDLE,
        LINK_WAIT,
        LINK_DONE
    } link_state_t;

    typedef enum logic {
        CORE_IDLE,
        CORE_REQ
    } core_state_t;

endpackage

// ==== bit_sync.sv ====
// Purpose: Two flip-flop synchroniser for one level.
// Assumes: Input is a level that stays long enough to be seen.
// Notes:   First stage feeds only the second stage.
`timescale 1ns/1ns
module bit_sync (
    input  wire logic clk_i,
    input  wire logic async_i,
    output logic      sync_o
);

    logic meta_reg;

    always_ff @(posedge clk_i) begin
        meta_reg <= async_i;
        sync_o   <= meta_reg;
    end

endmodule

// ==== host_bcu_model.sv ====
// Purpose: Host bus controller model driving split-strobe cycles.
// Assumes: Pins change just after a rising host_xfer_clk edge.
// Notes:   Released data lines show the inverse of the device value.
`timescale 1ns/1ns
module host_bcu_model (
    input  wire logic        clk_i,
    input  wire logic        ready_n_i,
    input  wire logic [15:0] dev_data_i,
    input  wire logic        dev_oe_i,
    output logic             select_n_o,
    output logic             rd_n_o,
    output logic             wr_n_o,
    output logic             upper_n_o,
    output logic [16:0]      addr_o,
    output logic [15:0]      data_o
);
    logic        drive_reg = 1'h0;
    logic [15:0] wd_reg    = 16'h0000;
    ////////////////////////////////////////////////////////////
    // Stale value never shown, so a missed capture cannot pass
    assign data_o = (drive_reg && dev_oe_i !== 1'h1) ? wd_reg : ~dev_data_i;
    initial begin
        select_n_o = 1'h1;
        rd_n_o = 1'h1;
        wr_n_o = 1'h1;
        upper_n_o = 1'h1;
        addr_o = 17'h00000;
    end
    task automatic access(input logic we, input logic [16:0] a, input logic word,
                          input logic [15:0] d, input int lim,
                          output logic [15:0] rd, output logic oe, output logic ok);
        int n;
        n = 0;
        ok = 1'h0;
        rd = 16'h0000;
        oe = 1'h0;
        @(posedge clk_i);
        addr_o <= a;
        upper_n_o <= ~word;
        wd_reg <= d;
        drive_reg <= we;
        @(posedge clk_i);
        select_n_o <= 1'h0;
        rd_n_o <= we;
        wr_n_o <= ~we;
        while (!ok && n < lim) begin
            @(posedge clk_i);
            n++;
            if (ready_n_i === 1'h1) begin
                ok = 1'h1;
                rd = dev_data_i;
                oe = dev_oe_i;
            end
        end
        select_n_o <= 1'h1;
        rd_n_o <= 1'h1;
        wr_n_o <= 1'h1;
        drive_reg <= 1'h0;
        repeat (3) @(posedge clk_i);
    endtask
endmodule

// ==== tb_top.sv ====
// Purpose: Self-checking bench for the split-strobe host bus port.
// Assumes: Core arbiter is modelled here with a settable grant delay.
// Notes:   Host cycles come from host_bcu_model on its own clock.
`timescale 1ns/1ns
module tb_top;
    logic clock_i = 1'h0, host_xfer_clk_i = 1'h0, sys_rst_i = 1'h1;
    logic panel_ctrl_select_n_i, read_strobe_n_i, low_write_strobe_n_i, upper_byte_strobe_n_i;
    logic bus_status_n_i = 1'h1, rd_wr_dir_i = 1'h1, acc_grant_i = 1'h0;
    logic strap_mode_bit0_i = 1'h1, strap_mode_bit1_i = 1'h1, strap_mode_bit2_i = 1'h1;
    logic strap_byte_order_i = 1'h0, ok, oe, port_data_oe_o, panel_ctrl_ready_n_o;
    logic acc_req_o, acc_we_o, acc_mem_sel_o, acc_reg_sel_o, split_mode_o, big_endian_o;
    logic [16:0] host_addr, acc_addr_o;
    logic [15:0] port_data_i, port_data_o, acc_wdata_o, rd, m, acc_rdata_i = 16'h0000;
    logic [1:0]  acc_be_o;
    logic [37:0] seen;
    logic [6:0]  t_we = 7'h27, t_wd = 7'h69;
    logic [16:0] t_a [7] = '{17'h00010, 17'h00021, 17'h00020, 17'h1ffe4, 17'h13fff,
                             17'h1ffe0, 17'h00000};
    logic [15:0] t_d [7] = '{16'h1234, 16'hab00, 16'h00cd, 16'h0000, 16'h0000, 16'h00ff,
                             16'h0000};
    logic [1:0]  t_be [7] = '{2'h3, 2'h2, 2'h1, 2'h3, 2'h2, 2'h3, 2'h3};
    int n_errors = 0, comparisons = 0, n_req = 0, wait_cnt = 0, arb_delay = 0, lim = 300;
    ////////////////////////////////////////////////////////////
    always #50 clock_i = ~clock_i;
    initial #7 forever #16 host_xfer_clk_i = ~host_xfer_clk_i;
    host_bcu_model host_u (.clk_i(host_xfer_clk_i), .ready_n_i(panel_ctrl_ready_n_o),
        .dev_data_i(port_data_o), .dev_oe_i(port_data_oe_o), .select_n_o(panel_ctrl_select_n_i),
        .rd_n_o(read_strobe_n_i), .wr_n_o(low_write_strobe_n_i),
        .upper_n_o(upper_byte_strobe_n_i), .addr_o(host_addr), .data_o(port_data_i));
    split_strobe_host_bus_port dut_u (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
        .host_xfer_clk_i(host_xfer_clk_i), .panel_ctrl_select_n_i(panel_ctrl_select_n_i),
        .read_strobe_n_i(read_strobe_n_i), .low_write_strobe_n_i(low_write_strobe_n_i),
        .upper_byte_strobe_n_i(upper_byte_strobe_n_i), .port_addr_msb_i(host_addr[16]),
        .port_addr_in_i(host_addr[15:1]), .port_addr_lsb_i(host_addr[0]),
        .port_data_i(port_data_i), .bus_status_n_i(bus_status_n_i), .rd_wr_dir_i(rd_wr_dir_i),
        .strap_mode_bit0_i(strap_mode_bit0_i), .strap_mode_bit1_i(strap_mode_bit1_i),
        .strap_mode_bit2_i(strap_mode_bit2_i), .strap_byte_order_i(strap_byte_order_i),
        .acc_grant_i(acc_grant_i), .acc_rdata_i(acc_rdata_i), .port_data_o(port_data_o),
        .port_data_oe_o(port_data_oe_o), .panel_ctrl_ready_n_o(panel_ctrl_ready_n_o),
        .acc_req_o(acc_req_o), .acc_we_o(acc_we_o), .acc_mem_sel_o(acc_mem_sel_o),
        .acc_reg_sel_o(acc_reg_sel_o), .acc_addr_o(acc_addr_o), .acc_be_o(acc_be_o),
        .acc_wdata_o(acc_wdata_o), .split_mode_o(split_mode_o), .big_endian_o(big_endian_o));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic summarize;
        if (n_errors == 0 && comparisons > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // Arbiter model: grant after arb_delay cycles, capture the request
    always @(posedge clock_i) begin
        acc_grant_i <= 1'h0;
        if (acc_req_o === 1'h1 && acc_grant_i !== 1'h1) begin
            chk(panel_ctrl_ready_n_o, 1'h0);
            if (wait_cnt >= arb_delay) begin
                acc_grant_i <= 1'h1;
                wait_cnt <= 0;
                n_req++;
                seen <= {acc_we_o, acc_mem_sel_o, acc_reg_sel_o, acc_be_o, acc_addr_o, acc_wdata_o};
            end else wait_cnt <= wait_cnt + 1;
        end
    end
    task automatic do_reset(input logic [4:0] st);
        @(posedge clock_i);
        // status strap driven from st[4] like the mode straps
        {bus_status_n_i, strap_byte_order_i, strap_mode_bit2_i} <= st[4:2];
        {strap_mode_bit1_i, strap_mode_bit0_i, rd_wr_dir_i, sys_rst_i} <= {st[1:0], 2'h3};
        repeat (6) @(posedge clock_i);
        chk({panel_ctrl_ready_n_o, port_data_oe_o, acc_req_o}, 3'h0);
        sys_rst_i <= 1'h0;
        repeat (12) @(posedge clock_i);
        chk(split_mode_o, &{st[4], st[2:0]});
        chk(big_endian_o, st[3]);
    endtask
    task automatic xfer(input logic we, input logic [16:0] a, input logic w, input logic [15:0] d);
        n_req = 0;
        host_u.access(we, a, w, d, lim, rd, oe, ok);
    endtask
    initial begin
        #3000000;
        n_errors++;
        summarize();
    end
    initial begin
        do_reset(5'h17);
        for (int i = 0; i < 7; i++) begin
            bus_status_n_i <= i[0];
            rd_wr_dir_i <= i[0];
            arb_delay = 3 * i;
            acc_rdata_i <= 16'h5a00 + 16'(i);
            xfer(t_we[i], t_a[i], t_wd[i], t_d[i]);
            m = (t_be[i] == 2'h3) ? 16'hffff : (t_be[i] == 2'h2) ? 16'hff00 : 16'h00ff;
            chk({ok, oe, 4'(n_req)}, {1'h1, ~t_we[i], 4'h1});
            chk(seen[37:16], {t_we[i], t_a[i] < 17'h14000, t_a[i] >= 17'h1ffe0, t_be[i],
                t_a[i]});
            if (t_we[i]) chk(seen[15:0], t_d[i]);
            else chk(rd & m, acc_rdata_i & m);
        end
        xfer(1'h0, 17'h14000, 1'h1, 16'h0000);
        chk({ok, 4'(n_req), rd}, {1'h1, 4'h0, 16'h0000});
        xfer(1'h0, 17'h1ffdf, 1'h1, 16'h0000);
        chk({ok, 4'(n_req), rd}, {1'h1, 4'h0, 16'h0000});
        do_reset(5'h1f);
        acc_rdata_i <= 16'h5aa5;
        xfer(1'h1, 17'h00100, 1'h1, 16'h1234);
        chk(seen[15:0], 16'h3412);
        xfer(1'h1, 17'h00100, 1'h0, 16'h00cd);
        chk({seen[34:33], seen[15:8]}, {2'h2, 8'hcd});
        xfer(1'h0, 17'h00102, 1'h1, 16'h0000);
        chk(rd, 16'ha55a);
        // Not split mode: cycle must never end, bounded wait
        do_reset(5'h07);
        lim = 40;
        xfer(1'h0, 17'h00000, 1'h1, 16'h0000);
        chk({ok, 4'(n_req)}, 5'h00);
        summarize();
    end
endmodule
